// file: verilog/ptd_regs.sv
// Top: checker status, RGMII delay, sync FIFO and loopback registers over AXI4-Lite.
// Assumes checker event pulses and delay line consumers share aclk.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Packet overflow flag at bit 10 sticks until counters are cleared.
// - Byte overflow flag at bit 9 clears only by writing one to bit 1.
// - Bits 7:0 show the captured count of erroneous received bytes.
// - Writing bit 0 or bit 1 freezes the error count shown.
// - With saturate select zero, error count stops at 0xff.
// - Writing bit 0 issues a lock strobe capturing counters without clearing.
// - Writing bit 1 captures counters then clears them and both flags.
// - Transmit clock delay from bits 7:4, (code+1) quarter ns, reset 0111.
// - Receive clock delay from bits 3:0, same steps, reset 0111.
// - Upper byte of delay register ignores writes and reads zero.
// - With saturate select zero, received-byte count stops at 0xffff.
module ptd_regs
    import ptd_pkg::*;
(
    input  wire logic              aclk,             // Clock, 40 MHz
    input  wire logic              aresetn,          // Sync reset, low active
    input  wire logic              ce,               // Clock enable, freezes all state
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,    // Write address
    input  wire logic              s_axil_awvalid,   // Write address valid
    output logic                   s_axil_awready,   // Write address ready
    input  wire logic [31:0]       s_axil_wdata,     // Write data
    input  wire logic [3:0]        s_axil_wstrb,     // Write byte strobes
    input  wire logic              s_axil_wvalid,    // Write data valid
    output logic                   s_axil_wready,    // Write data ready
    output logic [1:0]             s_axil_bresp,     // Write response
    output logic                   s_axil_bvalid,    // Write response valid
    input  wire logic              s_axil_bready,    // Write response ready
    input  wire logic [ADDR_W-1:0] s_axil_araddr,    // Read address
    input  wire logic              s_axil_arvalid,   // Read address valid
    output logic                   s_axil_arready,   // Read address ready
    output logic [31:0]            s_axil_rdata,     // Read data
    output logic [1:0]             s_axil_rresp,     // Read response
    output logic                   s_axil_rvalid,    // Read data valid
    input  wire logic              s_axil_rready,    // Read data ready
    input  wire logic              chk_byte_seen,    // Checker byte received
    input  wire logic              chk_byte_bad,     // Checker byte in error
    input  wire logic              chk_pkt_seen,     // Checker packet received
    output logic [3:0]             tx_delay_code,    // Transmit clock delay code
    output logic [3:0]             rx_delay_code,    // Receive clock delay code
    output logic [15:0]            sync_fifo_value,  // Sync FIFO setting
    output logic [15:0]            loopback_value,   // Loopback configuration
    output logic [15:0]            checker_received_bytes, // Captured byte count
    output logic                   irq               // Level interrupt
);
    ptd_cnt_if cif ();

    logic              wr_en;
    logic [11:0]       wr_idx;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [11:0]       rd_idx;
    logic [31:0]       rd_val;
    logic [3:0]        tx_dly_q;
    logic [3:0]        rx_dly_q;
    logic [15:0]       sync_q;
    logic [15:0]       loop_q;
    logic              sat_sel_q;
    logic [IRQ_W-1:0]  irq_sts_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              pkt_ovf_d1_q;
    logic              byte_ovf_d1_q;

    function automatic logic is_mapped(input logic [11:0] idx);
        is_mapped = (idx == IDX_CHK_STATUS) || (idx == IDX_CLK_DELAY) ||
                    (idx == IDX_SYNC_FIFO)  || (idx == IDX_LOOPBACK)  ||
                    (idx == IDX_CHK_MODE)   || (idx == IDX_IRQ_STATUS) ||
                    (idx == IDX_IRQ_MASK);
    endfunction

    ptd_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .awaddr  (s_axil_awaddr),
        .awvalid (s_axil_awvalid),
        .awready (s_axil_awready),
        .wdata   (s_axil_wdata),
        .wstrb   (s_axil_wstrb),
        .wvalid  (s_axil_wvalid),
        .wready  (s_axil_wready),
        .bresp   (s_axil_bresp),
        .bvalid  (s_axil_bvalid),
        .bready  (s_axil_bready),
        .araddr  (s_axil_araddr),
        .arvalid (s_axil_arvalid),
        .arready (s_axil_arready),
        .rdata   (s_axil_rdata),
        .rresp   (s_axil_rresp),
        .rvalid  (s_axil_rvalid),
        .rready  (s_axil_rready),
        .wr_en   (wr_en),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (is_mapped(wr_idx)),
        .rd_en   (),
        .rd_idx  (rd_idx),
        .rd_val  (rd_val),
        .rd_ok   (is_mapped(rd_idx))
    );

    ptd_counters u_cnt (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .byte_seen (chk_byte_seen),
        .byte_bad  (chk_byte_bad),
        .pkt_seen  (chk_pkt_seen),
        .cif       (cif)
    );

    // Decoded strobed writes; low byte lane carries every writable field except the upper bytes of sync FIFO and loopback
    wire wr_lo     = wr_en && wr_strb[0];
    wire wr_hi     = wr_en && wr_strb[1];
    wire wr_status = wr_lo && (wr_idx == IDX_CHK_STATUS);
    wire wr_delay  = wr_lo && (wr_idx == IDX_CLK_DELAY);
    wire wr_sync   = wr_en && (wr_idx == IDX_SYNC_FIFO);
    wire wr_loop   = wr_en && (wr_idx == IDX_LOOPBACK);
    wire wr_mode   = wr_lo && (wr_idx == IDX_CHK_MODE);
    wire wr_isc    = wr_lo && (wr_idx == IDX_IRQ_STATUS);
    wire wr_imask  = wr_lo && (wr_idx == IDX_IRQ_MASK);

    // Writing either strobe bit captures; bit 1 also clears
    assign cif.lock     = ce && wr_status && wr_data[BIT_LOCK];
    assign cif.clear    = ce && wr_status && wr_data[BIT_CLEAR];
    assign cif.saturate = !sat_sel_q;

    // Overflow rising edges and error-count saturation hits become interrupt events
    wire [IRQ_W-1:0] irq_evt;
    assign irq_evt[IRQ_PKT_OVF]  = cif.pkt_ovf && !pkt_ovf_d1_q;
    assign irq_evt[IRQ_BYTE_OVF] = cif.byte_ovf && !byte_ovf_d1_q;
    assign irq_evt[IRQ_ERR_SAT]  = cif.err_full && cif.saturate;

    wire [IRQ_W-1:0] irq_clr = wr_isc ? wr_data[IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_dly_q      <= RST_TX_DELAY;
            rx_dly_q      <= RST_RX_DELAY;
            sync_q        <= RST_SYNC_FIFO;
            loop_q        <= RST_LOOPBACK;
            sat_sel_q     <= RST_SAT_SELECT;
            irq_sts_q     <= '0;
            irq_mask_q    <= '0;
            pkt_ovf_d1_q  <= 1'b0;
            byte_ovf_d1_q <= 1'b0;
        end else if (ce) begin
            if (wr_delay) begin
                // Upper byte of the write is dropped
                tx_dly_q <= wr_data[TX_DLY_LSB +: 4];
                rx_dly_q <= wr_data[RX_DLY_LSB +: 4];
            end
            if (wr_sync && wr_strb[0])
                sync_q[7:0] <= wr_data[7:0];
            if (wr_sync && wr_hi)
                sync_q[15:8] <= wr_data[15:8];
            // Takes effect only after a device soft reset elsewhere
            if (wr_loop && wr_strb[0])
                loop_q[7:0] <= wr_data[7:0];
            if (wr_loop && wr_hi)
                loop_q[15:8] <= wr_data[15:8];
            if (wr_mode)
                sat_sel_q <= wr_data[0];
            if (wr_imask)
                irq_mask_q <= wr_data[IRQ_W-1:0];
            // Set wins over a same-cycle clear
            irq_sts_q     <= (irq_sts_q & ~irq_clr) | irq_evt;
            pkt_ovf_d1_q  <= cif.pkt_ovf;
            byte_ovf_d1_q <= cif.byte_ovf;
        end
    end

    // Read mux
    wire [31:0] rd_status = {21'h0, cif.pkt_ovf, cif.byte_ovf, 1'b0,
                             cif.err_snap};
    wire [31:0] rd_delay  = {24'h0, tx_dly_q, rx_dly_q};

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (rd_idx)
            IDX_CHK_STATUS: rd_val = rd_status;
            IDX_CLK_DELAY:  rd_val = rd_delay;
            IDX_SYNC_FIFO:  rd_val = {16'h0, sync_q};
            IDX_LOOPBACK:   rd_val = {16'h0, loop_q};
            IDX_CHK_MODE:   rd_val = {31'h0, sat_sel_q};
            IDX_IRQ_STATUS: rd_val = {{(32-IRQ_W){1'b0}}, irq_sts_q};
            IDX_IRQ_MASK:   rd_val = {{(32-IRQ_W){1'b0}}, irq_mask_q};
            default:        rd_val = 32'h0000_0000;
        endcase
    end

    assign tx_delay_code          = tx_dly_q;
    assign rx_delay_code          = rx_dly_q;
    assign sync_fifo_value        = sync_q;
    assign loopback_value         = loop_q;
    assign checker_received_bytes = cif.byte_snap;
    assign irq                    = |(irq_sts_q & irq_mask_q);
endmodule
`default_nettype wire

// file: verilog/ptd_pkg.sv
// Register map, field positions and reset values for the checker/delay/loopback bank.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package ptd_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] IDX_CHK_STATUS  = 12'h072;
    localparam logic [11:0] IDX_CLK_DELAY   = 12'h086;
    localparam logic [11:0] IDX_SYNC_FIFO   = 12'h0e9;
    localparam logic [11:0] IDX_LOOPBACK    = 12'h0fe;
    localparam logic [11:0] IDX_CHK_MODE    = 12'h100;
    localparam logic [11:0] IDX_IRQ_STATUS  = 12'h101;
    localparam logic [11:0] IDX_IRQ_MASK    = 12'h102;
    localparam int          ADDR_W          = 14;

    localparam int BIT_LOCK      = 0;
    localparam int BIT_CLEAR     = 1;
    localparam int BIT_BYTE_OVF  = 9;
    localparam int BIT_PKT_OVF   = 10;
    localparam int TX_DLY_LSB    = 4;
    localparam int RX_DLY_LSB    = 0;

    localparam logic [3:0]  RST_TX_DELAY   = 4'h7;
    localparam logic [3:0]  RST_RX_DELAY   = 4'h7;
    localparam logic [15:0] RST_SYNC_FIFO  = 16'h9f22;
    localparam logic [15:0] RST_LOOPBACK   = 16'h0001;
    localparam logic        RST_SAT_SELECT = 1'b0;
    localparam logic [7:0]  ERR_MAX        = 8'hff;
    localparam logic [15:0] BYTE_MAX       = 16'hffff;
    localparam logic [15:0] PKT_MAX        = 16'hffff;

    // Irq status bits
    localparam int IRQ_PKT_OVF  = 0;
    localparam int IRQ_BYTE_OVF = 1;
    localparam int IRQ_ERR_SAT  = 2;
    localparam int IRQ_W        = 3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: verilog/ptd_cnt_if.sv
// Counter control/status bundle between the register bank and checker counters.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ptd_cnt_if;
    logic        lock;       // Capture counters
    logic        clear;      // Capture then clear counters
    logic        saturate;   // Error and byte counters stop at maximum
    logic [7:0]  err_snap;   // Captured error-byte count
    logic [15:0] byte_snap;  // Captured received-byte count
    logic        pkt_ovf;    // Packet counter overflowed
    logic        byte_ovf;   // Byte counter overflowed
    logic        err_full;   // Error counter reached maximum (event pulse)
    modport bank (output lock, clear, saturate,
                  input err_snap, byte_snap, pkt_ovf, byte_ovf, err_full);
    modport cnt  (input lock, clear, saturate,
                  output err_snap, byte_snap, pkt_ovf, byte_ovf, err_full);
endinterface
`default_nettype wire

// file: verilog/ptd_counters.sv
// Checker counters with lock and clear strobes and sticky overflow flags.
// Assumes byte/error/packet event pulses are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ptd_counters
    import ptd_pkg::*;
(
    input  wire logic aclk,        // Clock
    input  wire logic aresetn,     // Sync reset, low active
    input  wire logic ce,          // Clock enable
    input  wire logic byte_seen,   // Checker received a byte
    input  wire logic byte_bad,    // That byte was in error
    input  wire logic pkt_seen,    // Checker received a packet
    ptd_cnt_if.cnt    cif          // Control and snapshots
);
    logic [7:0]  err_q;
    logic [15:0] byte_q;
    logic [15:0] pkt_q;
    logic        pkt_ovf_q;
    logic        byte_ovf_q;
    logic [7:0]  err_snap_q;
    logic [15:0] byte_snap_q;

    wire err_at_max  = (err_q == ERR_MAX);
    wire byte_at_max = (byte_q == BYTE_MAX);
    wire pkt_at_max  = (pkt_q == PKT_MAX);
    wire err_inc     = byte_seen && byte_bad && !(cif.saturate && err_at_max);
    wire byte_inc    = byte_seen && !(cif.saturate && byte_at_max);
    wire capture     = cif.lock || cif.clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q       <= 8'h00;
            byte_q      <= 16'h0000;
            pkt_q       <= 16'h0000;
            pkt_ovf_q   <= 1'b0;
            byte_ovf_q  <= 1'b0;
            err_snap_q  <= 8'h00;
            byte_snap_q <= 16'h0000;
        end else if (ce) begin
            if (capture) begin
                err_snap_q  <= err_q;
                byte_snap_q <= byte_q;
            end
            if (cif.clear) begin
                // Clear takes priority over a same-cycle count
                err_q      <= 8'h00;
                byte_q     <= 16'h0000;
                pkt_q      <= 16'h0000;
                pkt_ovf_q  <= 1'b0;
                byte_ovf_q <= 1'b0;
            end else begin
                if (err_inc)
                    err_q <= err_q + 8'h01;
                if (byte_inc)
                    byte_q <= byte_q + 16'h0001;
                if (pkt_seen)
                    pkt_q <= pkt_q + 16'h0001;
                if (pkt_seen && pkt_at_max)
                    pkt_ovf_q <= 1'b1;
                if (byte_inc && byte_at_max)
                    byte_ovf_q <= 1'b1;
            end
        end
    end

    assign cif.err_snap  = err_snap_q;
    assign cif.byte_snap = byte_snap_q;
    assign cif.pkt_ovf   = pkt_ovf_q;
    assign cif.byte_ovf  = byte_ovf_q;
    assign cif.err_full  = byte_seen && byte_bad && err_at_max && !cif.clear;
endmodule
`default_nettype wire

// file: verilog/ptd_axil_slave.sv
// AXI4-Lite handshake front end: one write and one read in flight.
// Assumes the master holds valid and payload until accepted.
`timescale 1ns/1ps
`default_nettype none
module ptd_axil_slave
    import ptd_pkg::*;
(
    input  wire logic              aclk,      // Clock
    input  wire logic              aresetn,   // Sync reset, low active
    input  wire logic              ce,        // Clock enable
    input  wire logic [ADDR_W-1:0] awaddr,    // Write address
    input  wire logic              awvalid,   // Write address valid
    output logic                   awready,   // Write address ready
    input  wire logic [31:0]       wdata,     // Write data
    input  wire logic [3:0]        wstrb,     // Byte strobes
    input  wire logic              wvalid,    // Write data valid
    output logic                   wready,    // Write data ready
    output logic [1:0]             bresp,     // Write response
    output logic                   bvalid,    // Write response valid
    input  wire logic              bready,    // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,    // Read address
    input  wire logic              arvalid,   // Read address valid
    output logic                   arready,   // Read address ready
    output logic [31:0]            rdata,     // Read data
    output logic [1:0]             rresp,     // Read response
    output logic                   rvalid,    // Read data valid
    input  wire logic              rready,    // Read data ready
    output logic                   wr_en,     // One-cycle register write
    output logic [11:0]            wr_idx,    // Register index written
    output logic [31:0]            wr_data,   // Data written
    output logic [3:0]             wr_strb,   // Strobes written
    input  wire logic              wr_ok,     // Write index is mapped
    output logic                   rd_en,     // One-cycle register read
    output logic [11:0]            rd_idx,    // Register index read
    input  wire logic [31:0]       rd_val,    // Read value, same cycle
    input  wire logic              rd_ok      // Read index is mapped
);
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] aw_q;
    logic [31:0]       w_q;
    logic [3:0]        s_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    wire aw_take = ce && awvalid && awready;
    wire w_take  = ce && wvalid && wready;
    wire ar_take = ce && arvalid && arready;

    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign wr_en   = ce && aw_have_q && w_have_q && !bvalid_q;
    assign wr_idx  = aw_q[ADDR_W-1:2];
    assign wr_data = w_q;
    assign wr_strb = s_q;
    assign rd_en   = ar_take;
    assign rd_idx  = araddr[ADDR_W-1:2];
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= '0;
            w_q       <= 32'h0000_0000;
            s_q       <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_q      <= awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_q      <= wdata;
                s_q      <= wstrb;
            end
            if (wr_en) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_ok ? rd_val : 32'h0000_0000;
                rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/ptd_regs_props.sv
// Concurrent checks on the ports of the checker, delay and loopback register bank.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ptd_regs_props
    import ptd_pkg::*;
(
    input wire logic        aclk,           // Clock
    input wire logic        aresetn,        // Sync reset, low active
    input wire logic        ce,             // Clock enable
    input wire logic        s_axil_awvalid, // Write address valid
    input wire logic        s_axil_awready, // Write address ready
    input wire logic        s_axil_wvalid,  // Write data valid
    input wire logic        s_axil_wready,  // Write data ready
    input wire logic        s_axil_bvalid,  // Write response valid
    input wire logic        s_axil_bready,  // Write response ready
    input wire logic        s_axil_arready, // Read address ready
    input wire logic [31:0] s_axil_rdata,   // Read data
    input wire logic        s_axil_rvalid,  // Read data valid
    input wire logic        s_axil_rready,  // Read data ready
    input wire logic [3:0]  tx_delay_code,  // Transmit delay code
    input wire logic [3:0]  rx_delay_code,  // Receive delay code
    input wire logic        irq             // Level interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_dly_rst;
        $rose(aresetn) |-> tx_delay_code == RST_TX_DELAY && rx_delay_code == RST_RX_DELAY && !irq;
    endproperty
    a_dly_rst: assert property (p_dly_rst) else $error("delay or irq wrong after reset");
    // Delay codes only move together with a completed register write
    property p_dly_wr;
        $changed(tx_delay_code) || $changed(rx_delay_code) |-> $rose(s_axil_bvalid);
    endproperty
    a_dly_wr: assert property (p_dly_wr) else $error("delay code moved without a write");
    property p_rd_hi;
        s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
    property p_bhold;
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold;
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_arrdy;
        s_axil_arready == !s_axil_rvalid;
    endproperty
    a_arrdy: assert property (p_arrdy) else $error("read address ready wrong");
    property p_bdone;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready && ce
            |=> ##1 s_axil_bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write response late");
    property p_awblk;
        s_axil_bvalid |-> !s_axil_awready;
    endproperty
    a_awblk: assert property (p_awblk) else $error("write address taken during response");
endmodule
bind ptd_regs ptd_regs_props u_props (.aclk, .aresetn, .ce, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_arready,
    .s_axil_rdata, .s_axil_rvalid, .s_axil_rready, .tx_delay_code, .rx_delay_code, .irq);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes the bank answers every request within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ptd_pkg::*;
    typedef struct {logic [11:0] idx; logic [31:0] wd; logic [31:0] rd;} ptd_row_t;
    logic              aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, q;
    logic [3:0]        wstrb, txd, rxd;
    logic              awready, wready, bvalid, arready, rvalid, irq, bseen, bbad, pseen;
    logic [1:0]        bresp, rresp, r;
    logic [15:0]       syncv, loopv, rxbytes;
    int                n_mismatch, comparisons;
    ptd_row_t          rows [6] = '{'{IDX_CLK_DELAY, 32'h0000_ffa5, 32'h0000_00a5},
        '{IDX_CLK_DELAY, 32'h0000_000f, 32'h0000_000f}, '{IDX_SYNC_FIFO, 32'hdead_9f22, 32'h9f22},
        '{IDX_LOOPBACK, 32'h0000_e720, 32'h0000_e720}, '{IDX_CHK_MODE, 32'h0, 32'h0},
        '{IDX_IRQ_MASK, 32'h7, 32'h7}};

    ptd_regs dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axil_awaddr(awaddr),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .chk_byte_seen(bseen), .chk_byte_bad(bbad),
        .chk_pkt_seen(pseen), .tx_delay_code(txd), .rx_delay_code(rxd),
        .sync_fifo_value(syncv), .loopback_value(loopv), .checker_received_bytes(rxbytes),
        .irq(irq));

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Ready rises with the request; one idle edge keeps calls from reassigning it in one step
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        logic a, w, ar, fin;
        fin = 1'b0;
        if (wr) begin
            awaddr <= {idx, 2'b00};
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int n = 0; n < 40 && !fin; n++) begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            ar = arvalid && arready;
            fin = wr ? bvalid : rvalid;
            q = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (ar) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk);
        if (!fin) begin
            n_mismatch++;
            complete_run();
        end
    endtask

    task automatic rchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(name, q, exp);
    endtask

    task automatic ev(input logic b, input logic e, input logic p, input int n);
        bseen <= b;
        bbad <= e;
        pseen <= p;
        repeat (n) @(posedge aclk);
        bseen <= 1'b0;
        bbad <= 1'b0;
        pseen <= 1'b0;
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, bseen, bbad, pseen} = '0;
        {awaddr, araddr, wdata} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("delay_rst", IDX_CLK_DELAY, 32'h77);
        chk("rresp_ok", {30'h0, r}, {30'h0, RESP_OKAY});
        rchk("sync_rst", IDX_SYNC_FIFO, 32'h9f22);
        rchk("loop_rst", IDX_LOOPBACK, 32'h0001);
        rchk("status_rst", IDX_CHK_STATUS, 32'h0);
        rchk("unmapped_rd", 12'h050, 32'h0);
        chk("unmapped_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        xfer(1'b1, 12'h050, 32'h1);
        chk("unmapped_bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].idx, rows[i].wd);
            chk("bresp_ok", {30'h0, r}, {30'h0, RESP_OKAY});
            rchk("row", rows[i].idx, rows[i].rd);
        end
        chk("tx_code", {28'h0, txd}, 32'h0);
        chk("rx_code", {28'h0, rxd}, 32'hf);
        chk("loop_port", {16'h0, loopv}, 32'he720);
        chk("sync_port", {16'h0, syncv}, 32'h9f22);
        ev(1'b1, 1'b1, 1'b0, 3);
        rchk("err_unlocked", IDX_CHK_STATUS, 32'h0);
        xfer(1'b1, IDX_CHK_STATUS, 32'h1);
        rchk("err_lock", IDX_CHK_STATUS, 32'h3);
        chk("bytes_lock", {16'h0, rxbytes}, 32'h3);
        ev(1'b1, 1'b1, 1'b0, 2);
        rchk("err_frozen", IDX_CHK_STATUS, 32'h3);
        xfer(1'b1, IDX_CHK_STATUS, 32'h1);
        rchk("err_relock", IDX_CHK_STATUS, 32'h5);
        xfer(1'b1, IDX_CHK_STATUS, 32'h2);
        rchk("err_clear", IDX_CHK_STATUS, 32'h5);
        ev(1'b1, 1'b0, 1'b0, 4);
        xfer(1'b1, IDX_CHK_STATUS, 32'h1);
        rchk("err_zeroed", IDX_CHK_STATUS, 32'h0);
        chk("bytes_zeroed", {16'h0, rxbytes}, 32'h4);
        xfer(1'b1, IDX_IRQ_MASK, 32'h0);
        ev(1'b1, 1'b1, 1'b0, 300);
        xfer(1'b1, IDX_CHK_STATUS, 32'h1);
        rchk("err_sat", IDX_CHK_STATUS, 32'hff);
        chk("bytes_sum", {16'h0, rxbytes}, 32'h130);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rchk("irq_status", IDX_IRQ_STATUS, 32'h4);
        xfer(1'b1, IDX_IRQ_MASK, 32'h4);
        chk("irq_on", {31'h0, irq}, 32'h1);
        xfer(1'b1, IDX_IRQ_STATUS, 32'h4);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        // Wrap mode lets the 16-bit byte counter roll over in one long burst, beside the packet counter, which wraps in either mode
        xfer(1'b1, IDX_CHK_MODE, 32'h1);
        xfer(1'b1, IDX_CHK_STATUS, 32'h2);
        ev(1'b1, 1'b0, 1'b1, 65536);
        xfer(1'b1, IDX_CHK_STATUS, 32'h1);
        rchk("ovf_kept", IDX_CHK_STATUS, 32'h600);
        rchk("ovf_irq", IDX_IRQ_STATUS, 32'h3);
        xfer(1'b1, IDX_CHK_STATUS, 32'h2);
        rchk("ovf_cleared", IDX_CHK_STATUS, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
